//--- rtl/bri_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module bri_i2c_slave (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   reset_n,
  // Bus pins
  input  wire logic   scl,
  input  wire logic   sda_in,
  output logic        sda_oe_n,
  // Conversion side
  bri_link_if.slave   link
);
  typedef struct packed {
    logic                      scl_s1, scl_s2, scl_d;
    logic                      sda_s1, sda_s2, sda_d;
    bri_pkg::bri_slave_state_t st;
    logic [3:0]                bitcnt;
    logic [7:0]                shreg;
    logic [1:0]                byte_idx;
    logic                      rd;
    logic                      rd_low;
    logic                      prefix_ok;
    logic                      read_armed;
    bri_pkg::bri_sel_t         pend;
    logic                      drive;
    logic                      start_press;
    logic                      start_temp;
  } bri_slave_reg_t;

  bri_slave_reg_t r_reg, r_next;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise   = r_reg.scl_s2 & ~r_reg.scl_d;
  assign scl_fall   = ~r_reg.scl_s2 & r_reg.scl_d;
  assign start_cond = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d
                      & ~r_reg.sda_s2;
  assign stop_cond  = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d
                      & r_reg.sda_s2;

  always_comb begin
    r_next             = r_reg;
    r_next.scl_s1      = scl;
    r_next.scl_s2      = r_reg.scl_s1;
    r_next.scl_d       = r_reg.scl_s2;
    r_next.sda_s1      = sda_in;
    r_next.sda_s2      = r_reg.sda_s1;
    r_next.sda_d       = r_reg.sda_s2;
    r_next.start_press = 1'b0;
    r_next.start_temp  = 1'b0;
    if (stop_cond) begin
      // Selection takes effect only on the closing STOP
      r_next.start_press = (r_reg.pend == bri_pkg::SEL_PRESS);
      r_next.start_temp  = (r_reg.pend == bri_pkg::SEL_TEMP);
      r_next.pend        = bri_pkg::SEL_NONE;
      r_next.prefix_ok   = 1'b0;
      r_next.read_armed  = 1'b0;
      r_next.drive       = 1'b0;
      r_next.st          = bri_pkg::SL_IDLE;
    end else if (start_cond) begin
      // Repeated START keeps the readback arming
      r_next.st       = bri_pkg::SL_RECV;
      r_next.bitcnt   = 4'h0;
      r_next.byte_idx = 2'h0;
      r_next.drive    = 1'b0;
      r_next.pend     = bri_pkg::SEL_NONE;
    end else begin
      case (r_reg.st)
        bri_pkg::SL_RECV: begin
          if (scl_rise && r_reg.bitcnt != 4'h8) begin
            r_next.shreg  = {r_reg.shreg[6:0], r_reg.sda_s2};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == 4'h8) begin
            r_next.st    = bri_pkg::SL_ACK;
            r_next.drive = 1'b1;
            if (r_reg.byte_idx == 2'h0) begin
              if (r_reg.shreg == bri_pkg::ADDR_WR) begin
                r_next.rd = 1'b0;
              end else if (r_reg.shreg == bri_pkg::ADDR_RD
                           && r_reg.read_armed) begin
                r_next.rd = 1'b1;
              end else begin
                r_next.st    = bri_pkg::SL_IDLE;
                r_next.drive = 1'b0;
              end
            end else if (r_reg.byte_idx == 2'h1) begin
              r_next.prefix_ok  = (r_reg.shreg == bri_pkg::CMD_PREFIX);
              r_next.read_armed = (r_reg.shreg == bri_pkg::CMD_READBACK);
              r_next.pend       = bri_pkg::SEL_NONE;
            end else if (r_reg.byte_idx == 2'h2 && r_reg.prefix_ok) begin
              if (r_reg.shreg == bri_pkg::CMD_SEL_PRESS) begin
                r_next.pend = bri_pkg::SEL_PRESS;
              end else if (r_reg.shreg == bri_pkg::CMD_SEL_TEMP) begin
                r_next.pend = bri_pkg::SEL_TEMP;
              end else begin
                r_next.pend = bri_pkg::SEL_NONE;
              end
              r_next.read_armed = 1'b0;
            end else begin
              // Extra bytes cancel any pending selection
              r_next.pend       = bri_pkg::SEL_NONE;
              r_next.read_armed = 1'b0;
              r_next.prefix_ok  = 1'b0;
            end
          end
        end
        bri_pkg::SL_ACK: begin
          if (scl_fall) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.byte_idx != 2'h3) begin
              r_next.byte_idx = r_reg.byte_idx + 2'h1;
            end
            if (r_reg.rd) begin
              // Upper byte first, MSB first
              r_next.shreg  = link.result[15:8];
              r_next.rd_low = 1'b0;
              r_next.drive  = ~link.result[15];
              r_next.st     = bri_pkg::SL_SEND;
            end else begin
              r_next.drive = 1'b0;
              r_next.st    = bri_pkg::SL_RECV;
            end
          end
        end
        bri_pkg::SL_SEND: begin
          if (scl_fall) begin
            if (r_reg.bitcnt == 4'h7) begin
              r_next.drive = 1'b0;
              r_next.st    = bri_pkg::SL_MACK;
            end else begin
              r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
              r_next.drive  = ~r_reg.shreg[6];
              r_next.bitcnt = r_reg.bitcnt + 4'h1;
            end
          end
        end
        bri_pkg::SL_MACK: begin
          if (scl_rise) begin
            if (!r_reg.sda_s2 && !r_reg.rd_low) begin
              r_next.bitcnt = 4'h0;
            end else begin
              r_next.bitcnt = 4'hF;
            end
          end else if (scl_fall) begin
            if (r_reg.bitcnt == 4'h0) begin
              r_next.shreg  = link.result[7:0];
              r_next.rd_low = 1'b1;
              r_next.drive  = ~link.result[7];
              r_next.st     = bri_pkg::SL_SEND;
            end else begin
              r_next.st = bri_pkg::SL_IDLE;
            end
          end
        end
        default: begin
          r_next.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_reg            <= '0;
      r_reg.scl_s1     <= 1'b1;
      r_reg.scl_s2     <= 1'b1;
      r_reg.scl_d      <= 1'b1;
      r_reg.sda_s1     <= 1'b1;
      r_reg.sda_s2     <= 1'b1;
      r_reg.sda_d      <= 1'b1;
      r_reg.st         <= bri_pkg::SL_IDLE;
      r_reg.pend       <= bri_pkg::SEL_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_oe_n         = ~r_reg.drive;
  assign link.start_press = r_reg.start_press;
  assign link.start_temp  = r_reg.start_temp;
endmodule
`default_nettype wire

//--- rtl/bri_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bri_link_if;
  logic        start_press;
  logic        start_temp;
  logic [15:0] result;
  modport slave (output start_press, output start_temp, input result);
  modport core  (input start_press, input start_temp, output result);
endinterface
`default_nettype wire

//--- rtl/bri_pkg.sv
package bri_pkg;
  // Bus address bytes
  localparam logic [7:0] ADDR_WR       = 8'hEE;
  localparam logic [7:0] ADDR_RD       = 8'hEF;
  // Command bytes
  localparam logic [7:0] CMD_PREFIX    = 8'hFF;
  localparam logic [7:0] CMD_SEL_PRESS = 8'hF0;
  localparam logic [7:0] CMD_SEL_TEMP  = 8'hE8;
  localparam logic [7:0] CMD_READBACK  = 8'hFD;
  localparam int         RESULT_W      = 16;
  // Conversion timing in sample-clock cycles, longest time rounds down
  localparam longint     CONV_TIME_US  = 35000;
  localparam longint     MCLK_HZ       = 32768;
  localparam int         CONV_MCLK_CYCLES =
    int'((CONV_TIME_US * MCLK_HZ) / 64'd1000000);
  localparam int         CONV_CNT_W    = 11;

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_RECV = 3'b001,
    SL_ACK  = 3'b010,
    SL_SEND = 3'b011,
    SL_MACK = 3'b100
  } bri_slave_state_t;

  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_PRESS = 2'b01,
    SEL_TEMP  = 2'b10
  } bri_sel_t;

  typedef enum logic [0:0] {
    CV_DOWN = 1'b0,
    CV_RUN  = 1'b1
  } bri_conv_state_t;
endpackage

//--- rtl/bri_readout.sv
`timescale 1ns/1ps
`default_nettype none
module bri_readout #(
  parameter int CONV_MCLK_CYCLES = bri_pkg::CONV_MCLK_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Bus pins
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Converter pins
  input  wire logic        mclk,
  input  wire logic        converter_reset_n,
  // Modulator samples
  input  wire logic [15:0] pressure_count,
  input  wire logic [15:0] temperature_count,
  // Status
  output logic             converting,
  output logic             powered_down
);
  typedef struct packed {
    logic                          mclk_s1, mclk_s2, mclk_d;
    logic                          xr_s1, xr_s2;
    bri_pkg::bri_conv_state_t      st;
    logic                          is_temp;
    logic [bri_pkg::CONV_CNT_W-1:0] cnt;
    logic [bri_pkg::RESULT_W-1:0]  result;
  } bri_core_reg_t;

  localparam logic [bri_pkg::CONV_CNT_W-1:0] CNT_LAST =
    bri_pkg::CONV_CNT_W'(CONV_MCLK_CYCLES - 1);

  bri_core_reg_t c_reg, c_next;
  bri_link_if    link ();
  logic          mclk_rise;

  bri_i2c_slave u_slave (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .scl      (scl),
    .sda_in   (sda_in),
    .sda_oe_n (sda_oe_n),
    .link     (link.slave)
  );

  assign mclk_rise = c_reg.mclk_s2 & ~c_reg.mclk_d;

  always_comb begin
    c_next         = c_reg;
    c_next.mclk_s1 = mclk;
    c_next.mclk_s2 = c_reg.mclk_s1;
    c_next.mclk_d  = c_reg.mclk_s2;
    c_next.xr_s1   = converter_reset_n;
    c_next.xr_s2   = c_reg.xr_s1;
    case (c_reg.st)
      bri_pkg::CV_DOWN: begin
        if (c_reg.xr_s2 && (link.start_press || link.start_temp)) begin
          c_next.st      = bri_pkg::CV_RUN;
          c_next.is_temp = link.start_temp;
          c_next.cnt     = '0;
        end
      end
      bri_pkg::CV_RUN: begin
        if (!c_reg.xr_s2) begin
          // Converter in reset: abort, keep last result
          c_next.st = bri_pkg::CV_DOWN;
        end else if (mclk_rise) begin
          if (c_reg.cnt == CNT_LAST) begin
            c_next.result = c_reg.is_temp ? temperature_count
                                          : pressure_count;
            c_next.st     = bri_pkg::CV_DOWN;
          end else begin
            c_next.cnt = c_reg.cnt + 1'b1;
          end
        end
      end
      default: begin
        c_next.st = bri_pkg::CV_DOWN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      c_reg    <= '0;
      c_reg.st <= bri_pkg::CV_DOWN;
    end else begin
      c_reg <= c_next;
    end
  end

  assign link.result  = c_reg.result;
  assign sda_out      = 1'b0;
  assign converting   = (c_reg.st == bri_pkg::CV_RUN);
  assign powered_down = (c_reg.st == bri_pkg::CV_DOWN);
endmodule
`default_nettype wire

//--- sim/bri_master.sv
`timescale 1ns/1ps
`default_nettype none
module bri_master #(
  parameter int HALF = 250
) (
  // Clock
  input  wire logic core_clk,
  // Bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv,
  // Converter control
  output logic      mclk,
  output logic      converter_reset_n
);
  int mdiv;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    mclk = 1'b0;
    converter_reset_n = 1'b0;
    mdiv = 0;
  end
  always @(posedge core_clk) begin
    mdiv <= (mdiv == 19) ? 0 : mdiv + 1;
    if (!converter_reset_n) mclk <= 1'b0;
    else if (mdiv == 19) mclk <= !mclk;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wake;
    converter_reset_n <= 1'b1;
    hw(8);
  endtask
  task automatic sleep;
    converter_reset_n <= 1'b0;
    hw(1);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_drv <= b;
    hw(HALF / 2);
    scl <= 1'b1;
    hw(HALF);
    r = sda_line;
    scl <= 1'b0;
    hw(HALF / 2);
  endtask
  task automatic start;
    sda_drv <= 1'b1;
    hw(HALF / 2);
    scl <= 1'b1;
    hw(HALF / 2);
    sda_drv <= 1'b0;
    hw(HALF / 2);
    scl <= 1'b0;
    hw(HALF / 2);
  endtask
  task automatic stop;
    sda_drv <= 1'b0;
    hw(HALF / 2);
    scl <= 1'b1;
    hw(HALF / 2);
    sda_drv <= 1'b1;
    hw(8);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nak, r);
  endtask
endmodule
`default_nettype wire

//--- sim/bri_readout_props.sv
`timescale 1ns/1ps
`default_nettype none
module bri_readout_props #(
  parameter int CONV_MCLK_CYCLES = 4
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Bus and converter pins
  input wire logic        scl,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        mclk,
  input wire logic        converter_reset_n,
  input wire logic [15:0] pressure_count,
  input wire logic [15:0] temperature_count,
  // Status
  input wire logic        converting,
  input wire logic        powered_down
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [11:0] cnt_reg;
  logic        mclk_reg;
  // Raw sample clock rises seen while a conversion runs
  always_ff @(posedge core_clk) begin
    mclk_reg <= mclk;
    if (!reset_n || !converting) cnt_reg <= 12'h000;
    else if (mclk && !mclk_reg) cnt_reg <= cnt_reg + 12'h001;
  end
  property p_pd_inv;
    converting != powered_down;
  endproperty
  a_pd_inv: assert property (p_pd_inv) else $error("power state wrong");
  // A conversion must end by itself after its count of sample clock rises
  property p_auto_down;
    converting && converter_reset_n |-> cnt_reg <= CONV_MCLK_CYCLES + 1;
  endproperty
  a_auto_down: assert property (p_auto_down) else $error("no power down");
  property p_sda_out;
    sda_out == 1'b0;
  endproperty
  a_sda_out: assert property (p_sda_out) else $error("sda drive high");
  property p_converter_reset_n_hold;
    (!converter_reset_n) [*6] |-> !converting;
  endproperty
  a_converter_reset_n_hold: assert property (p_converter_reset_n_hold) else $error("ran in reset");
  property p_abort;
    $fell(converter_reset_n) && converting |-> ##[1:8] !converting;
  endproperty
  a_abort: assert property (p_abort) else $error("abort missed");
  property p_start_idle;
    $rose(converting) |-> scl && sda_in && converter_reset_n;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("bad start");
  property p_conv_len;
    $fell(converting) && converter_reset_n |->
      cnt_reg >= CONV_MCLK_CYCLES - 1 && cnt_reg <= CONV_MCLK_CYCLES + 1;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("bad length");
  property p_oe_scl;
    $changed(sda_oe_n) |-> !scl;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved");
  property p_ack_width;
    $fell(sda_oe_n) |-> !sda_oe_n [*8];
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("short low");
endmodule
bind bri_readout bri_readout_props #(
  .CONV_MCLK_CYCLES(CONV_MCLK_CYCLES)
) i_bri_readout_props (
  .core_clk(core_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mclk(mclk),
  .converter_reset_n(converter_reset_n), .pressure_count(pressure_count),
  .temperature_count(temperature_count), .converting(converting),
  .powered_down(powered_down)
);
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk, reset_n, sda_out, sda_oe_n, converting, powered_down;
  logic        scl, sda_drv, mclk, converter_reset_n;
  logic [15:0] pressure_count, temperature_count;
  int          error_cnt, compares;
  wire logic   sda_line = sda_drv & (sda_oe_n | sda_out);
  bri_readout #(.CONV_MCLK_CYCLES(4)) i_bri_readout (
    .core_clk(core_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mclk(mclk),
    .converter_reset_n(converter_reset_n), .pressure_count(pressure_count),
    .temperature_count(temperature_count), .converting(converting),
    .powered_down(powered_down));
  bri_master i_bri_master (.core_clk(core_clk), .sda_line(sda_line),
    .scl(scl), .sda_drv(sda_drv), .mclk(mclk),
    .converter_reset_n(converter_reset_n));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_conv(input logic lvl);
    int n;
    n = 0;
    while (converting !== lvl && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk(converting, lvl);
  endtask
  task automatic select(input logic [7:0] cmd);
    logic a;
    i_bri_master.start();
    i_bri_master.wbyte(bri_pkg::ADDR_WR, a);
    chk(a, 1'b1);
    i_bri_master.wbyte(bri_pkg::CMD_PREFIX, a);
    chk(a, 1'b1);
    i_bri_master.wbyte(cmd, a);
    chk(a, 1'b1);
    i_bri_master.stop();
  endtask
  task automatic readback(input logic [15:0] exp);
    logic       a;
    logic [7:0] hi, lo;
    i_bri_master.start();
    i_bri_master.wbyte(bri_pkg::ADDR_WR, a);
    chk(a, 1'b1);
    i_bri_master.wbyte(bri_pkg::CMD_READBACK, a);
    chk(a, 1'b1);
    i_bri_master.start();
    i_bri_master.wbyte(bri_pkg::ADDR_RD, a);
    chk(a, 1'b1);
    i_bri_master.rbyte(1'b0, hi);
    i_bri_master.rbyte(1'b1, lo);
    i_bri_master.stop();
    chk({hi, lo}, exp);
  endtask
  task automatic test_refuse;
    logic a;
    i_bri_master.start();
    i_bri_master.wbyte(bri_pkg::ADDR_RD, a);
    chk(a, 1'b0);
    i_bri_master.stop();
    $display("test_refuse done");
  endtask
  task automatic test_conv(input logic [7:0] cmd, input logic [15:0] exp);
    i_bri_master.wake();
    select(cmd);
    wait_conv(1'b1);
    wait_conv(1'b0);
    chk(powered_down, 1'b1);
    pressure_count <= 16'h0F0F;
    temperature_count <= 16'hF0F0;
    i_bri_master.sleep();
    readback(exp);
    $display("test_conv %h done", cmd);
  endtask
  task automatic test_abort;
    i_bri_master.wake();
    select(bri_pkg::CMD_SEL_PRESS);
    wait_conv(1'b1);
    i_bri_master.sleep();
    repeat (10) @(posedge core_clk);
    chk(converting, 1'b0);
    $display("test_abort done");
  endtask
  initial begin
    reset_n = 1'b0;
    pressure_count = 16'h0000;
    temperature_count = 16'h0000;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    test_refuse();
    pressure_count <= 16'hA55A;
    temperature_count <= 16'h3CC3;
    test_conv(bri_pkg::CMD_SEL_PRESS, 16'hA55A);
    pressure_count <= 16'h0001;
    temperature_count <= 16'h8EC3;
    test_conv(bri_pkg::CMD_SEL_TEMP, 16'h8EC3);
    test_abort();
    results();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
